//--- design/ext_bus_ctrl.sv
// External program/data bus control unit beside a signal-processor core.
// Assumes the core holds its request stable while stall_out is high.
`timescale 1ns/1ps
`include "ext_bus_ctrl_defs.svh"

module ext_bus_ctrl #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Core side
  input  wire logic [15:0] fetch_addr_in,
  input  wire ext_bus_ctrl_pkg::core_req_t data_req_in,
  input  wire logic        prog_write_in,
  input  wire logic        boot_read_in,
  input  wire logic        core_mem_enable_in,
  input  wire logic        monitor_active_in,
  input  wire logic        boot_active_in,
  input  wire logic [3:0]  ram_bank_select_in,
  output logic      [15:0] fetch_data_out,
  output logic      [15:0] rdata_out,
  output logic             stall_out,
  output logic             ram_powerdown_bypass_out,
  // Circular buffer arbitration
  input  wire logic        pcm_req_in,
  output logic             circ_grant_core_out,
  // External bus
  output logic      [15:0] ext_addr_bus_out,
  input  wire logic [15:0] ext_data_bus_in,
  output logic      [15:0] ext_data_bus_out,
  output logic             ext_data_bus_oe_out,
  output logic             ext_rd_n_out,
  output logic             ext_wr_n_out,
  output logic             ext_prog_sel_n_out,
  // Interrupt sources
  input  wire logic        frame_sync_in,
  input  wire logic        mailbox_irq_in,
  input  wire logic        emu_break_in,
  input  wire logic        pin_cs_in,
  input  wire logic        pin_wr_in,
  input  wire logic        pin_abort_in,
  input  wire logic        test_irq_select_in,
  output ext_bus_ctrl_pkg::irq_set_t irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [15:0] ext_din_s1_q;
  logic [15:0] ext_din_q;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_s1_q     <= 6'h00;
      pin_s2_q     <= 6'h00;
      ext_din_s1_q <= 16'h0000;
      ext_din_q    <= 16'h0000;
    end
    else
    begin
      pin_s1_q     <= {frame_sync_in, pin_cs_in, pin_wr_in, pin_abort_in,
                       test_irq_select_in, mailbox_irq_in};
      pin_s2_q     <= pin_s1_q;
      ext_din_s1_q <= ext_data_bus_in;
      ext_din_q    <= ext_din_s1_q;
    end
  end

  wire fsync_s   = pin_s2_q[5];
  wire cs_s      = pin_s2_q[4];
  wire wr_s      = pin_s2_q[3];
  wire abort_s   = pin_s2_q[2];
  wire tif_s     = pin_s2_q[1];
  wire mbox_s    = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  wire [15:0] daddr     = data_req_in.addr;
  wire is_ext_data      = data_req_in.req &&
                          (in_range(daddr, `EXTDATA_LO, `EXTDATA_HI) ||
                           in_range(daddr, `MAILBOX_LO, `MAILBOX_HI));
  wire is_mailbox       = in_range(daddr, `MAILBOX_LO, `MAILBOX_HI);
  wire is_circ          = data_req_in.req &&
                          in_range(daddr, `CIRC_LO, `CIRC_HI);
  wire is_reg           = data_req_in.req && (daddr[15:8] == 8'hC0);
  // Mailbox writes let through only for monitor or boot code
  wire mbox_wr_ok       = monitor_active_in || boot_active_in;
  wire wr_blocked       = data_req_in.wr && is_mailbox && !mbox_wr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2:0] data_wait_count_q;
  logic       bypass_q;
  logic       memen_seen_q;
  logic       circen_seen_q;
  wire  [7:0] load_cnt;
  wire  [7:0] load_max;

  wire reg_wr      = is_reg && data_req_in.wr && !stall_out;
  wire reg_rd      = is_reg && !data_req_in.wr;
  wire circ_enable = core_mem_enable_in || pcm_req_in;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      data_wait_count_q <= `MEMCFG_RESET;
      bypass_q          <= 1'b0;
      memen_seen_q      <= 1'b0;
      circen_seen_q     <= 1'b0;
    end
    else
    begin
      if (reg_wr && daddr == `MEMCFG_ADDR)
        data_wait_count_q <= data_req_in.wdata[2:0];
      if (reg_wr && daddr == `TESTCFG_ADDR)
        bypass_q <= data_req_in.wdata[`TCFG_BYPASS_BIT];
      memen_seen_q  <= core_mem_enable_in;
      circen_seen_q <= circ_enable;
    end
  end

  wire [15:0] memcfg_rd  = {13'h0000, data_wait_count_q};
  wire [15:0] testcfg_rd = {bypass_q, memen_seen_q, circen_seen_q,
                            ram_bank_select_in, 9'h000};

  frame_load_stats #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_stats (
    .clk_sys_in             (clk_sys_in),
    .rst_in                 (rst_in),
    .frame_sync_in          (fsync_s),
    .cnt_read_in            (reg_rd && daddr == `LOADCNT_ADDR),
    .max_write_in           (reg_wr && daddr == `LOADMAX_ADDR),
    .max_wdata_in           (data_req_in.wdata[7:0]),
    .frame_load_counter_out (load_cnt),
    .frame_load_max_out     (load_max)
  );

  wire [15:0] reg_rdata =
      (daddr == `MEMCFG_ADDR)  ? memcfg_rd :
      (daddr == `TESTCFG_ADDR) ? testcfg_rd :
      (daddr == `LOADCNT_ADDR) ? {8'h00, load_cnt} :
      (daddr == `LOADMAX_ADDR) ? {8'h00, load_max} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // External bus sequencer

  ext_bus_ctrl_pkg::bus_state_t state_q;
  ext_bus_ctrl_pkg::bus_state_t state_d;
  logic [2:0]  wait_cnt_q;
  logic [2:0]  wait_cnt_d;
  logic [15:0] fetch_data_q;
  logic [15:0] rdata_q;
  logic [2:0]  circ_wait_q;
  logic [1:0]  rd_cap_q;
  logic [1:0]  fetch_cap_q;

  // Boot ROM reads share the data wait count
  wire data_needed = is_ext_data || boot_read_in;
  wire data_waits_done = (wait_cnt_q == data_wait_count_q);
  wire pw_waits_done   = (wait_cnt_q == `PROG_WRITE_WAITS - 3'h1);
  // Pin data lands two edges late through the synchroniser
  wire rd_cap_now      = (state_q == ext_bus_ctrl_pkg::ST_DATA) &&
                         data_waits_done &&
                         !(data_req_in.wr && !boot_read_in);
  wire fetch_cap_now   = (state_q == ext_bus_ctrl_pkg::ST_FETCH) &&
                         !prog_write_in;

  always_comb
  begin
    state_d    = state_q;
    wait_cnt_d = 3'h0;
    unique case (state_q)
      ext_bus_ctrl_pkg::ST_FETCH:
        if (prog_write_in)
          state_d = ext_bus_ctrl_pkg::ST_PWRITE;
        else if (data_needed)
          state_d = ext_bus_ctrl_pkg::ST_GAP1;
      ext_bus_ctrl_pkg::ST_GAP1:
        state_d = ext_bus_ctrl_pkg::ST_DATA;
      ext_bus_ctrl_pkg::ST_DATA:
        if (data_waits_done)
          state_d = ext_bus_ctrl_pkg::ST_GAP2;
        else
          wait_cnt_d = wait_cnt_q + 3'h1;
      ext_bus_ctrl_pkg::ST_GAP2:
        state_d = ext_bus_ctrl_pkg::ST_FETCH;
      ext_bus_ctrl_pkg::ST_PWRITE:
        if (pw_waits_done)
          state_d = ext_bus_ctrl_pkg::ST_FETCH;
        else
          wait_cnt_d = wait_cnt_q + 3'h1;
      default:
        state_d = ext_bus_ctrl_pkg::ST_FETCH;
    endcase
  end

  // PCM port owns the circular buffer when both ask, until the core has waited 4 cycles
  wire circ_lose = is_circ && pcm_req_in &&
                   (circ_wait_q < `CIRC_MAX_DELAY);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q      <= ext_bus_ctrl_pkg::ST_FETCH;
      wait_cnt_q   <= 3'h0;
      fetch_data_q <= 16'h0000;
      rdata_q      <= 16'h0000;
      circ_wait_q  <= 3'h0;
      rd_cap_q     <= 2'b00;
      fetch_cap_q  <= 2'b00;
    end
    else
    begin
      state_q    <= state_d;
      wait_cnt_q <= wait_cnt_d;
      circ_wait_q <= circ_lose ? circ_wait_q + 3'h1 : 3'h0;
      rd_cap_q    <= {rd_cap_q[0], rd_cap_now};
      fetch_cap_q <= {fetch_cap_q[0], fetch_cap_now};
      if (fetch_cap_q[1])
        fetch_data_q <= ext_din_q;
      if (rd_cap_q[1])
        rdata_q <= ext_din_q;
      else if (reg_rd)
        rdata_q <= reg_rdata;
    end
  end

  wire in_fetch = (state_q == ext_bus_ctrl_pkg::ST_FETCH);
  wire in_data  = (state_q == ext_bus_ctrl_pkg::ST_DATA);
  wire in_pw    = (state_q == ext_bus_ctrl_pkg::ST_PWRITE);
  wire data_wr  = data_req_in.wr && !boot_read_in;

  // Stall covers the first gap, data waits, write waits, arbitration
  assign stall_out = (in_fetch && (data_needed || prog_write_in)) ||
                     (state_q == ext_bus_ctrl_pkg::ST_GAP1) ||
                     (in_data && !data_waits_done) ||
                     (in_pw && !pw_waits_done) ||
                     circ_lose;

  assign circ_grant_core_out = is_circ && !circ_lose;

  // Shared address and data pins
  assign ext_addr_bus_out    = in_data ? daddr : fetch_addr_in;
  assign ext_data_bus_out    = data_req_in.wdata;
  assign ext_data_bus_oe_out = (in_data && data_wr && !wr_blocked) || in_pw;
  assign ext_rd_n_out        = !((in_fetch && !prog_write_in) ||
                                 (in_data && !data_wr));
  assign ext_wr_n_out        = !((in_data && data_wr && !wr_blocked) ||
                                 (in_pw && pw_waits_done));
  assign ext_prog_sel_n_out  = !(in_fetch || in_pw);
  assign fetch_data_out      = fetch_data_q;
  assign rdata_out           = rdata_q;
  assign ram_powerdown_bypass_out = bypass_q;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt source selection

  // Normal sources, or test pins and fetch address bits, per select flag
  assign irq_out.irq0     = tif_s ? fetch_addr_in[8] : fsync_s;
  assign irq_out.irq1     = tif_s ? fetch_addr_in[9] : 1'b0;
  assign irq_out.irq2     = tif_s ? cs_s : mbox_s;
  assign irq_out.nmi      = tif_s ? wr_s : 1'b0;
  assign irq_out.brk      = tif_s ? abort_s : emu_break_in;
  assign irq_out.wait_req = tif_s ? fetch_addr_in[7] : stall_out;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_fetch_no_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (in_fetch && !data_needed && !prog_write_in && !circ_lose) |-> !stall_out)
    else $error("fetch stalled");

  a_gap_after_fetch: assert property (@(posedge clk_sys_in)
    disable iff (rst_in)
    (in_fetch && data_needed && !prog_write_in) |=>
    state_q == ext_bus_ctrl_pkg::ST_GAP1 ##1 in_data)
    else $error("gap order broken");

  a_data_bounded: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(in_data) |-> ##[0:7] (state_d == ext_bus_ctrl_pkg::ST_GAP2))
    else $error("data phase too long");

  a_pwrite_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(in_pw) |-> in_pw [*3] ##1 in_fetch)
    else $error("program write waits wrong");

  a_wait_reset: assert property (@(posedge clk_sys_in)
    $fell(rst_in) |-> data_wait_count_q == 3'h7)
    else $error("wait count reset wrong");

  a_memen_seen: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 memen_seen_q == $past(core_mem_enable_in))
    else $error("memory enable echo wrong");

  a_mbox_block: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (in_data && is_mailbox && data_req_in.wr && !mbox_wr_ok)
    |-> ext_wr_n_out)
    else $error("mailbox write leaked");

  a_circ_bound: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    circ_lose [*4] |=> !circ_lose)
    else $error("circular buffer delay too long");

endmodule

//--- inc/ext_bus_ctrl_defs.svh
// Offsets, field positions, reset values and timing counts of the
// external bus control unit. Definitions only.
`ifndef EXT_BUS_CTRL_DEFS_SVH
`define EXT_BUS_CTRL_DEFS_SVH

`define MEMCFG_ADDR        16'hC002
`define TESTCFG_ADDR       16'hC003
`define LOADCNT_ADDR       16'hC004
`define LOADMAX_ADDR       16'hC005
`define MEMCFG_RESET       3'h7
`define TCFG_BYPASS_BIT    15
`define TCFG_MEMEN_BIT     14
`define TCFG_CIREN_BIT     13
`define TCFG_BANK_LSB      9
`define EXTDATA_LO         16'h4000
`define EXTDATA_HI         16'hBFFF
`define MAILBOX_LO         16'hF400
`define MAILBOX_HI         16'hF7EF
`define CIRC_LO            16'hF000
`define CIRC_HI            16'hF0FF
`define PROG_WRITE_WAITS   3'h3
`define CIRC_MAX_DELAY     3'h4
`define CLK_PERIOD_PS      4000
`define TICK_PERIOD_PS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_PS / `CLK_PERIOD_PS)

`endif

//--- inc/ext_bus_ctrl_pkg.sv
// Types shared by the external bus control unit.
// Assumes the defs header supplies all numbers except the state codes, which are set here.
package ext_bus_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'b000,
    ST_GAP1   = 3'b001,
    ST_DATA   = 3'b010,
    ST_GAP2   = 3'b011,
    ST_PWRITE = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic irq0;
    logic irq1;
    logic irq2;
    logic nmi;
    logic brk;
    logic wait_req;
  } irq_set_t;

endpackage

//--- design/frame_load_stats.sv
// Per-frame load statistics counter and its companion max register.
// Assumes frame_sync_in already synchronised to clk_sys_in.
`timescale 1ns/1ps
`include "ext_bus_ctrl_defs.svh"

module frame_load_stats #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       frame_sync_in,
  input  wire logic       cnt_read_in,
  input  wire logic       max_write_in,
  input  wire logic [7:0] max_wdata_in,
  output logic      [7:0] frame_load_counter_out,
  output logic      [7:0] frame_load_max_out
);

  logic [15:0] tick_q;
  logic        fs_prev_q;
  logic        read_seen_q;
  logic [7:0]  cnt_q;
  logic [7:0]  max_q;

  wire tick_done = (tick_q == 16'(TICK_CYCLES - 1));
  wire fs_rise   = frame_sync_in && !fs_prev_q;
  wire clr_cnt   = fs_rise && (read_seen_q || cnt_read_in);

  // Prescaler and edge state restart; an unknown prescaler never ticks
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_q      <= 16'h0000;
      fs_prev_q   <= 1'b0;
      read_seen_q <= 1'b0;
    end
    else
    begin
      tick_q    <= tick_done ? 16'h0000 : tick_q + 16'h0001;
      fs_prev_q <= frame_sync_in;
      if (fs_rise)
        read_seen_q <= 1'b0;
      else if (cnt_read_in)
        read_seen_q <= 1'b1;
    end
  end

  // No reset: contents survive a chip reset
  always_ff @(posedge clk_sys_in)
  begin
    if (clr_cnt)
      cnt_q <= 8'h00;
    else if (tick_done)
      cnt_q <= cnt_q + 8'h01;
    if (max_write_in)
      max_q <= max_wdata_in;
  end

  assign frame_load_counter_out = cnt_q;
  assign frame_load_max_out     = max_q;

endmodule

//--- bench/ext_mem_model.sv
// Behavioural external SRAM on the shared program/data bus.
// Assumes active-low strobes and one clock shared with the unit.
`timescale 1ns/1ps

module ext_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        slow_in,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;
  logic        late_q;
  logic        drive;

  // Slow part answers only from the second strobe cycle
  assign drive = !rd_n_in && (late_q || !slow_in);

  always_ff @(posedge clk_sys_in)
  begin
    if (!wr_n_in)
      mem[addr_in[7:0]] <= wdata_in;
    late_q <= !rd_n_in;
    if (drive)
      last_q <= mem[addr_in[7:0]];
  end

  // Released bus flips, so a stale word is never mistaken for data
  assign rdata_out = drive ? mem[addr_in[7:0]] : ~last_q;
endmodule

//--- bench/testbench.sv
// Self-checking bench for the external bus control unit.
// Assumes the unit's package and defs header are compiled first.
`timescale 1ns/1ps

module testbench;
  logic        clk_sys_in, rst_in, prog_write_in, boot_read_in;
  logic        core_mem_enable_in, monitor_active_in, boot_active_in;
  logic        pcm_req_in, frame_sync_in, mailbox_irq_in, emu_break_in;
  logic        pin_cs_in, pin_wr_in, pin_abort_in, test_irq_select_in;
  logic        stall_out, ram_powerdown_bypass_out, ext_rd_n_out;
  logic        ext_wr_n_out, slow, due;
  logic [3:0]  ram_bank_select_in;
  logic [15:0] fetch_addr_in, rdata_out, ext_addr_bus_out, fetch_data_out;
  logic [15:0] ext_data_bus_in, ext_data_bus_out;
  logic [15:0] exp_q [$];
  int          n_errors, checks_done, cycles, sc;
  ext_bus_ctrl_pkg::core_req_t data_req_in;
  ext_bus_ctrl_pkg::irq_set_t  irq_out;

  ext_bus_ctrl #(.TICK_CYCLES(4)) DUT (
    .clk_sys_in, .rst_in, .fetch_addr_in, .data_req_in, .prog_write_in,
    .boot_read_in, .core_mem_enable_in, .monitor_active_in,
    .boot_active_in, .ram_bank_select_in, .fetch_data_out, .rdata_out,
    .stall_out, .ram_powerdown_bypass_out, .pcm_req_in,
    .circ_grant_core_out(), .ext_addr_bus_out, .ext_data_bus_in,
    .ext_data_bus_out, .ext_data_bus_oe_out(), .ext_rd_n_out,
    .ext_wr_n_out, .ext_prog_sel_n_out(), .frame_sync_in, .mailbox_irq_in,
    .emu_break_in, .pin_cs_in, .pin_wr_in, .pin_abort_in,
    .test_irq_select_in, .irq_out
  );

  ext_mem_model mem_model (
    .clk_sys_in,
    .addr_in   (ext_addr_bus_out),
    .rd_n_in   (ext_rd_n_out),
    .wr_n_in   (ext_wr_n_out),
    .wdata_in  (ext_data_bus_out),
    .slow_in   (slow),
    .rdata_out (ext_data_bus_in)
  );

  always #2 clk_sys_in = ~clk_sys_in;

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One core request held until the edge where stall is seen low
  task automatic seq(input logic wr, input logic [15:0] a, d,
                     input logic pw, br, ck, input logic [15:0] e,
                     output int n);
    @(negedge clk_sys_in);
    data_req_in <= '{req: !(pw | br), wr: wr, addr: a, wdata: d};
    prog_write_in <= pw;
    boot_read_in <= br;
    if (ck)
      exp_q.push_back(e);
    #1;
    n = 0;
    while (stall_out !== 1'b0 && n < 40)
    begin
      @(negedge clk_sys_in);
      #1;
      n++;
    end
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    data_req_in.req <= 1'b0;
    prog_write_in <= 1'b0;
    boot_read_in <= 1'b0;
    // Pin read data reaches rdata_out two edges after the data phase
    if (ck)
    begin
      repeat (2) @(negedge clk_sys_in);
      due <= 1'b1;
      @(negedge clk_sys_in);
      due <= 1'b0;
    end
  endtask

  task automatic rd(input logic [15:0] a, e);
    seq(1'b0, a, 16'h0000, 1'b0, 1'b0, 1'b1, e, sc);
  endtask

  task automatic wr(input logic [15:0] a, d);
    seq(1'b1, a, d, 1'b0, 1'b0, 1'b0, 16'h0000, sc);
  endtask

  task automatic pulse();
    frame_sync_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    frame_sync_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_in)
    if (due)
      check(rdata_out, exp_q.pop_front());

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    logic [15:0] d, v;
    int          w;
    {clk_sys_in, prog_write_in, boot_read_in, core_mem_enable_in} = '0;
    {monitor_active_in, boot_active_in, pcm_req_in, frame_sync_in} = '0;
    {mailbox_irq_in, emu_break_in, pin_cs_in, pin_wr_in} = '0;
    {pin_abort_in, test_irq_select_in, slow, due} = '0;
    {n_errors, checks_done, cycles} = '0;
    data_req_in = '0;
    fetch_addr_in = 16'h0000;
    rst_in = 1'b1;
    void'($urandom(82324));
    ram_bank_select_in = 4'($urandom);
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;

    rd(16'hC002, 16'h0007);
    rd(16'hC003, {3'b000, ram_bank_select_in, 9'h000});
    rd(16'hC00A, 16'h0000);
    note("reset values");

    core_mem_enable_in = 1'b1;
    wr(16'hC003, 16'hFFFF);
    check({15'h0000, ram_powerdown_bypass_out}, 16'h0001);
    rd(16'hC003, {3'b111, ram_bank_select_in, 9'h000});
    core_mem_enable_in = 1'b0;
    pcm_req_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    rd(16'hC003, {3'b101, ram_bank_select_in, 9'h000});
    pcm_req_in = 1'b0;
    wr(16'hC003, 16'h0000);
    note("observe register");

    for (w = 0; w < 8; w++)
    begin
      d = 16'($urandom);
      slow = (w > 3);
      wr(16'hC002, {d[15:3], 3'(w)});
      rd(16'hC002, 16'(w));
      seq(1'b1, 16'h4010 + 16'(w), d, 1'b0, 1'b0, 1'b0, 16'h0000, sc);
      check(16'(sc), 16'(2 + w));
      seq(1'b0, 16'h4010 + 16'(w), 16'h0000, 1'b0, 1'b0, 1'b1, d, sc);
      check(16'(sc), 16'(2 + w));
      seq(1'b0, 16'hC000, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0000, sc);
      check(16'(sc), 16'(2 + w));
    end
    note("wait states");

    boot_active_in = 1'b1;
    wr(16'hF420, d);
    boot_active_in = 1'b0;
    wr(16'hF420, ~d);
    rd(16'hF420, d);
    monitor_active_in = 1'b1;
    wr(16'hF420, ~d);
    rd(16'hF420, ~d);
    monitor_active_in = 1'b0;
    note("mailbox");

    fetch_addr_in = 16'h0030;
    seq(1'b0, 16'h0000, d, 1'b1, 1'b0, 1'b0, 16'h0000, sc);
    check(16'(sc), 16'h0003);
    check(mem_model.mem[8'h30], d);
    repeat (6) @(negedge clk_sys_in);
    check(fetch_data_out, d);
    pcm_req_in = 1'b1;
    seq(1'b1, 16'hF005, d, 1'b0, 1'b0, 1'b0, 16'h0000, sc);
    check(16'(sc > 0 && sc < 5), 16'h0001);
    pcm_req_in = 1'b0;
    note("program write and circular buffer");

    for (w = 0; w < 8; w++)
    begin
      v = 16'($urandom);
      {frame_sync_in, mailbox_irq_in, emu_break_in, pin_cs_in} = v[3:0];
      {pin_wr_in, pin_abort_in, test_irq_select_in} = v[6:4];
      fetch_addr_in = 16'($urandom);
      repeat (4) @(negedge clk_sys_in);
      d = 16'(test_irq_select_in ?
          {fetch_addr_in[8], fetch_addr_in[9], pin_cs_in, pin_wr_in,
           pin_abort_in, fetch_addr_in[7]} :
          {frame_sync_in, 1'b0, mailbox_irq_in, 1'b0, emu_break_in, 1'b0});
      check(16'(irq_out), d);
    end
    {frame_sync_in, test_irq_select_in, fetch_addr_in} = '0;
    note("interrupt sources");

    seq(1'b0, 16'hC004, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, sc);
    pulse();
    repeat (100) @(negedge clk_sys_in);
    pulse();
    seq(1'b0, 16'hC004, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, sc);
    v = rdata_out;
    check(16'(v > 16'd20), 16'h0001);
    repeat (38) @(negedge clk_sys_in);
    v = {8'h00, v[7:0] + 8'd10};
    rd(16'hC004, v);
    pulse();
    seq(1'b0, 16'hC004, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, sc);
    check(16'(rdata_out < 16'd5), 16'h0001);
    d = 16'($urandom);
    wr(16'hC005, {d[15:8], 8'h10});
    rd(16'hC005, 16'h0010);
    if (v > 16'h0010)
      wr(16'hC005, v);
    rst_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd(16'hC005, v);
    rd(16'hC002, 16'h0007);
    note("load statistics");
    conclude();
  end
endmodule
